// ==== swrx_fifo.v ====
// small synchronous fifo with valid and ready on both sides
// assumes a single clock and synchronous active-low reset
`timescale 1ns/100ps
module swrx_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_sys,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ==== swrx_line_src.sv ====
// serial line source: pre-digitised line codes for one receiver
// assumes high-speed sampling, one sample every 10 clocks
`timescale 1ns/100ps
module swrx_line_src (
    input wire clk_sys,
    output reg [1:0] line_code
);
    initial line_code = 2'h0;
    task hold(input [1:0] code, input integer n);
        begin
            line_code <= code;
            repeat (n * 10) @(posedge clk_sys);
        end
    endtask
    // bit index bad_at carries an out-of-range level, 32 means none
    task send(input [31:0] w, input integer space, input integer bad_at);
        integer i;
        begin
            for (i = 0; i < 32; i = i + 1) begin
                hold((i == bad_at) ? 2'h3 : (w[i] ? 2'h1 : 2'h2), 5);
                hold(2'h0, space - 5);
            end
            // long null gap so the next word is always rearmed
            hold(2'h0, 60);
        end
    endtask
endmodule

// ==== swrx_map.vh ====
// constants for the serial word receiver status and bus mapping block
// assumes inclusion by the sampler and the top design files of the block
`ifndef SWRX_MAP_VH
`define SWRX_MAP_VH
// status register bit positions
`define SWRX_SR_RX1_READY 0
`define SWRX_SR_RX1_HALF 1
`define SWRX_SR_RX1_FULL 2
`define SWRX_SR_RX2_READY 3
`define SWRX_SR_RX2_HALF 4
`define SWRX_SR_RX2_FULL 5
`define SWRX_SR_TX_EMPTY 6
`define SWRX_SR_TX_FULL 7
`define SWRX_SR_TX_HALF 8
`define SWRX_SR_WIDTH 9
// sampling and timing counts
`define SWRX_SAMP_LEN 10
`define SWRX_SAMP_VALID 3
`define SWRX_BIT_MIN 8
`define SWRX_BIT_MAX 12
`define SWRX_DIV_HIGH 10
`define SWRX_DIV_LOW 80
`define SWRX_GAP_NULLS 3
`define SWRX_WORD_BITS 32
// line state codes
`define SWRX_LINE_NULL 2'h0
`define SWRX_LINE_ONE 2'h1
`define SWRX_LINE_ZERO 2'h2
`define SWRX_LINE_BAD 2'h3
`endif

// ==== swrx_sampler.v ====
// one receiver: sample shift registers, bit timing, word-gap counting
// assumes line levels already digitised into one/zero/null/bad codes
`timescale 1ns/100ps
`include "swrx_map.vh"
module swrx_sampler #(
    parameter SLEN = `SWRX_SAMP_LEN
) (
    input wire clk_sys,
    input wire rst_b,
    input wire slow_sel,
    input wire rate_check_disable_n,
    input wire [1:0] line_code,
    output reg word_valid_q,
    output reg [31:0] word_q
);
    reg [6:0] div_q;
    reg samp_en_q;
    reg [SLEN-1:0] one_sr_q;
    reg [SLEN-1:0] zero_sr_q;
    reg [SLEN-1:0] null_sr_q;
    reg [5:0] nbits_q;
    reg [4:0] space_q;
    reg armed_q;
    reg pend_q;
    reg pend_val_q;
    reg [1:0] gap_cnt_q;
    reg [6:0] gap_div_q;
    reg [31:0] shift_q;
    localparam [6:0] DIV_TOP_LOW = `SWRX_DIV_LOW - 1;
    localparam [6:0] DIV_TOP_HIGH = `SWRX_DIV_HIGH - 1;
    wire [6:0] div_top;
    wire up_one;
    wire up_zero;
    wire lo_null;
    wire up_null;
    wire bit_seen;
    wire space_ok;
    assign div_top = slow_sel ? DIV_TOP_LOW : DIV_TOP_HIGH;
    // three matching samples in the upper end of the window, and for nulls also in the lower end
    assign up_one = &one_sr_q[SLEN-1:SLEN-`SWRX_SAMP_VALID];
    assign up_zero = &zero_sr_q[SLEN-1:SLEN-`SWRX_SAMP_VALID];
    assign up_null = &null_sr_q[SLEN-1:SLEN-`SWRX_SAMP_VALID];
    assign lo_null = &null_sr_q[`SWRX_SAMP_VALID-1:0];
    // a new bit: fresh one/zero edge entering the upper window
    assign bit_seen = samp_en_q && (up_one || up_zero) && pend_q == 1'b0 && armed_q;
    // space_q is cleared on the bit's own sample, so it trails the spacing by one
    assign space_ok = !rate_check_disable_n ||
        (space_q >= `SWRX_BIT_MIN - 1 && space_q <= `SWRX_BIT_MAX - 1);
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            div_q <= 7'h00;
            samp_en_q <= 1'b0;
        end else begin
            // ten samples per bit time at either rate
            samp_en_q <= (div_q == 7'h00);
            div_q <= (div_q == 7'h00) ? div_top : div_q - 1'b1;
        end
    end
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            one_sr_q <= {SLEN{1'b0}};
            zero_sr_q <= {SLEN{1'b0}};
            null_sr_q <= {SLEN{1'b0}};
            nbits_q <= 6'h00;
            space_q <= 5'h00;
            armed_q <= 1'b0;
            pend_q <= 1'b0;
            pend_val_q <= 1'b0;
            gap_cnt_q <= 2'h0;
            gap_div_q <= 7'h00;
            shift_q <= 32'h0000_0000;
            word_valid_q <= 1'b0;
            word_q <= 32'h0000_0000;
        end else begin
            word_valid_q <= 1'b0;
            if (samp_en_q) begin
                // lsb is the oldest sample, msb the newest
                one_sr_q <= {line_code == `SWRX_LINE_ONE, one_sr_q[SLEN-1:1]};
                zero_sr_q <= {line_code == `SWRX_LINE_ZERO, zero_sr_q[SLEN-1:1]};
                null_sr_q <= {line_code == `SWRX_LINE_NULL, null_sr_q[SLEN-1:1]};
                if (space_q != 5'h1f) begin
                    space_q <= space_q + 1'b1;
                end
            end
            if (!armed_q) begin
                // word gap: sample nulls once per sample period (div_top + 1 clocks)
                if (gap_div_q == div_top) begin
                    gap_div_q <= 7'h00;
                    if (up_null && lo_null) begin
                        if (gap_cnt_q == `SWRX_GAP_NULLS - 1) begin
                            armed_q <= 1'b1;
                            nbits_q <= 6'h00;
                        end
                        gap_cnt_q <= gap_cnt_q + 1'b1;
                    end else begin
                        gap_cnt_q <= 2'h0;
                    end
                end else begin
                    gap_div_q <= gap_div_q + 1'b1;
                end
            end else if (samp_en_q && line_code == `SWRX_LINE_BAD) begin
                armed_q <= 1'b0;
                gap_cnt_q <= 2'h0;
                pend_q <= 1'b0;
            end else if (bit_seen) begin
                if (nbits_q != 6'h00 && !space_ok) begin
                    armed_q <= 1'b0;
                    gap_cnt_q <= 2'h0;
                end else begin
                    pend_q <= 1'b1;
                    pend_val_q <= up_one;
                    space_q <= 5'h00;
                end
            end else if (pend_q && samp_en_q) begin
                if (up_null) begin
                    // bit completes once three nulls trail it; the older window bits
                    // still hold the previous gap and would end the bit too early
                    pend_q <= 1'b0;
                    shift_q <= {pend_val_q, shift_q[31:1]};
                    nbits_q <= nbits_q + 1'b1;
                    if (nbits_q == `SWRX_WORD_BITS - 1) begin
                        word_valid_q <= 1'b1;
                        word_q <= {pend_val_q, shift_q[31:1]};
                        armed_q <= 1'b0;
                        gap_cnt_q <= 2'h0;
                        gap_div_q <= 7'h00;
                    end
                end else if (rate_check_disable_n && space_q >= `SWRX_SAMP_LEN) begin
                    armed_q <= 1'b0;
                    pend_q <= 1'b0;
                    gap_cnt_q <= 2'h0;
                end
            end
        end
    end
endmodule

// ==== swrx_status_map.v ====
// top: two receivers, receive fifos, status register and host byte mapping
// assumes host strobes and line codes are synchronous to clk_sys
`timescale 1ns/100ps
`include "swrx_map.vh"
module swrx_status_map #(
    parameter RX_DEPTH = 32,
    parameter RX_AW = 5,
    parameter HALF_LEVEL = 16,
    parameter BUF_DEPTH = 4,
    parameter BUF_AW = 2
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [1:0] rx_one_line_code,
    input wire [1:0] rx_two_line_code,
    input wire rx_one_slow_sel,
    input wire rx_two_slow_sel,
    input wire rate_check_disable_n,
    input wire bus_bit_order_select,
    input wire status_read_strobe_n,
    input wire byte_sel,
    input wire rx_one_output_enable_n,
    input wire rx_two_output_enable_n,
    input wire tx_fifo_empty,
    input wire tx_fifo_full,
    input wire tx_fifo_half_full,
    output reg [15:0] host_bus_out,
    output reg host_bus_oe,
    output reg rx_one_ready_n,
    output reg rx_two_ready_n,
    output reg rx_one_half_full_n,
    output reg rx_two_half_full_n,
    output reg rx_one_full_n,
    output reg rx_two_full_n,
    output reg tx_fifo_full_n,
    output reg tx_fifo_half_full_n
);
    wire [1:0] word_valid;
    wire [31:0] word_data [0:1];
    wire [1:0] buf_valid;
    wire [1:0] buf_ready;
    wire [31:0] buf_data [0:1];
    wire [1:0] line_code [0:1];
    wire [1:0] slow_sel;
    wire [1:0] en_n;
    reg [31:0] mem0 [0:RX_DEPTH-1];
    reg [31:0] mem1 [0:RX_DEPTH-1];
    reg [RX_AW:0] cnt_q [0:1];
    reg [RX_AW-1:0] wr_q [0:1];
    reg [RX_AW-1:0] rd_q [0:1];
    reg [1:0] byte_done_q;
    reg [1:0] en_prev_q;
    reg [31:0] head [0:1];
    reg [15:0] mapped;
    reg [31:0] sel_word;
    wire [`SWRX_SR_WIDTH-1:0] status_bits;
    wire [1:0] rd_pulse;
    wire rd_any;
    wire rd_start;
    wire sel_two;
    assign line_code[0] = rx_one_line_code;
    assign line_code[1] = rx_two_line_code;
    assign slow_sel = {rx_two_slow_sel, rx_one_slow_sel};
    // receiver two only drives the bus when receiver one is not enabled
    assign en_n = {rx_two_output_enable_n | ~rx_one_output_enable_n, rx_one_output_enable_n};
    assign sel_two = rx_one_output_enable_n;
    always @* begin
        head[0] = mem0[rd_q[0]];
        head[1] = mem1[rd_q[1]];
    end
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : rx
            swrx_sampler u_samp (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .slow_sel(slow_sel[g]),
                .rate_check_disable_n(rate_check_disable_n),
                .line_code(line_code[g]),
                .word_valid_q(word_valid[g]),
                .word_q(word_data[g])
            );
            swrx_fifo #(.WIDTH(32), .DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .in_valid(word_valid[g]),
                .in_ready(),
                .in_data(word_data[g]),
                .out_valid(buf_valid[g]),
                .out_ready(buf_ready[g]),
                .out_data(buf_data[g])
            );
            // buffer drains only while the main fifo takes words; a full fifo
            // overwrites its last slot, so the drain never stalls for long
            assign buf_ready[g] = ~(rd_pulse[g] & (cnt_q[g] == RX_DEPTH[RX_AW:0]));
            // second byte read completes the word and pops it
            assign rd_pulse[g] = ~en_n[g] & en_prev_q[g] & byte_sel & byte_done_q[g];
            always @(posedge clk_sys) begin
                if (!rst_b) begin
                    cnt_q[g] <= {(RX_AW+1){1'b0}};
                    wr_q[g] <= {RX_AW{1'b0}};
                    rd_q[g] <= {RX_AW{1'b0}};
                    byte_done_q[g] <= 1'b0;
                    en_prev_q[g] <= 1'b1;
                end else begin
                    en_prev_q[g] <= en_n[g];
                    if (~en_n[g] & en_prev_q[g] & ~byte_sel) begin
                        byte_done_q[g] <= 1'b1;
                    end else if (rd_pulse[g]) begin
                        byte_done_q[g] <= 1'b0;
                    end
                    if (buf_valid[g] & buf_ready[g]) begin
                        if (cnt_q[g] != RX_DEPTH[RX_AW:0]) begin
                            wr_q[g] <= wr_q[g] + 1'b1;
                        end
                    end
                    if (rd_pulse[g] && cnt_q[g] != {(RX_AW+1){1'b0}}) begin
                        rd_q[g] <= rd_q[g] + 1'b1;
                    end
                    if (buf_valid[g] & buf_ready[g] & (cnt_q[g] != RX_DEPTH[RX_AW:0]) &
                        ~(rd_pulse[g] & (cnt_q[g] != {(RX_AW+1){1'b0}}))) begin
                        cnt_q[g] <= cnt_q[g] + 1'b1;
                    end else if (rd_pulse[g] & (cnt_q[g] != {(RX_AW+1){1'b0}}) &
                        ~(buf_valid[g] & buf_ready[g] & (cnt_q[g] != RX_DEPTH[RX_AW:0]))) begin
                        cnt_q[g] <= cnt_q[g] - 1'b1;
                    end
                end
            end
        end
    endgenerate
    // full fifo: newest word overwrites the last slot
    always @(posedge clk_sys) begin
        if (buf_valid[0] & buf_ready[0]) begin
            mem0[(cnt_q[0] == RX_DEPTH[RX_AW:0]) ? wr_q[0] - 1'b1 : wr_q[0]] <= buf_data[0];
        end
        if (buf_valid[1] & buf_ready[1]) begin
            mem1[(cnt_q[1] == RX_DEPTH[RX_AW:0]) ? wr_q[1] - 1'b1 : wr_q[1]] <= buf_data[1];
        end
    end
    assign status_bits[`SWRX_SR_RX1_READY] = (cnt_q[0] != {(RX_AW+1){1'b0}});
    assign status_bits[`SWRX_SR_RX1_HALF] = (cnt_q[0] >= HALF_LEVEL);
    assign status_bits[`SWRX_SR_RX1_FULL] = (cnt_q[0] == RX_DEPTH[RX_AW:0]);
    assign status_bits[`SWRX_SR_RX2_READY] = (cnt_q[1] != {(RX_AW+1){1'b0}});
    assign status_bits[`SWRX_SR_RX2_HALF] = (cnt_q[1] >= HALF_LEVEL);
    assign status_bits[`SWRX_SR_RX2_FULL] = (cnt_q[1] == RX_DEPTH[RX_AW:0]);
    assign status_bits[`SWRX_SR_TX_EMPTY] = tx_fifo_empty;
    assign status_bits[`SWRX_SR_TX_FULL] = tx_fifo_full;
    assign status_bits[`SWRX_SR_TX_HALF] = tx_fifo_half_full;
    assign rd_any = ~en_n[0] | ~en_n[1];
    assign rd_start = (~en_n[0] & en_prev_q[0]) | (~en_n[1] & en_prev_q[1]);
    integer i;
    always @* begin
        sel_word = sel_two ? head[1] : head[0];
        mapped = 16'h0000;
        if (!bus_bit_order_select) begin
            if (!byte_sel) begin
                // word bit n sits at index n-1
                mapped[15:11] = {sel_word[12], sel_word[11], sel_word[10],
                    sel_word[9], sel_word[8]};
                mapped[10:8] = {sel_word[30], sel_word[29], sel_word[31]};
                for (i = 0; i < 8; i = i + 1) begin
                    mapped[7-i] = sel_word[i];
                end
            end else begin
                mapped = sel_word[28:13];
            end
        end else begin
            if (!byte_sel) begin
                mapped = sel_word[15:0];
            end else begin
                mapped = {sel_word[31], sel_word[30:16]};
            end
        end
    end
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            host_bus_out <= 16'h0000;
            host_bus_oe <= 1'b0;
            rx_one_ready_n <= 1'b1;
            rx_two_ready_n <= 1'b1;
            rx_one_half_full_n <= 1'b1;
            rx_two_half_full_n <= 1'b1;
            rx_one_full_n <= 1'b1;
            rx_two_full_n <= 1'b1;
            tx_fifo_full_n <= 1'b1;
            tx_fifo_half_full_n <= 1'b1;
        end else begin
            rx_one_ready_n <= ~status_bits[`SWRX_SR_RX1_READY];
            rx_one_half_full_n <= ~status_bits[`SWRX_SR_RX1_HALF];
            rx_one_full_n <= ~status_bits[`SWRX_SR_RX1_FULL];
            rx_two_ready_n <= ~status_bits[`SWRX_SR_RX2_READY];
            rx_two_half_full_n <= ~status_bits[`SWRX_SR_RX2_HALF];
            rx_two_full_n <= ~status_bits[`SWRX_SR_RX2_FULL];
            tx_fifo_full_n <= ~status_bits[`SWRX_SR_TX_FULL];
            tx_fifo_half_full_n <= ~status_bits[`SWRX_SR_TX_HALF];
            if (!status_read_strobe_n && !byte_sel) begin
                host_bus_out <= {7'h00, status_bits};
                host_bus_oe <= 1'b1;
            end else if (rd_any) begin
                // byte latched as the enable falls, so the pop behind it stays hidden
                if (rd_start) begin
                    host_bus_out <= mapped;
                end
                host_bus_oe <= 1'b1;
            end else begin
                host_bus_out <= 16'h0000;
                host_bus_oe <= 1'b0;
            end
        end
    end
endmodule

// ==== swrx_status_map_props.sv ====
// assertions for the status and bus map top
// assumes binding to swrx_status_map; sees only its ports
`timescale 1ns/100ps
module swrx_status_map_props (
    input wire clk_sys,
    input wire rst_b,
    input wire status_read_strobe_n,
    input wire byte_sel,
    input wire rx_one_output_enable_n,
    input wire rx_two_output_enable_n,
    input wire tx_fifo_empty,
    input wire tx_fifo_full,
    input wire tx_fifo_half_full,
    input wire [15:0] host_bus_out,
    input wire host_bus_oe,
    input wire rx_one_ready_n,
    input wire rx_two_ready_n,
    input wire rx_one_half_full_n,
    input wire rx_two_half_full_n,
    input wire rx_one_full_n,
    input wire rx_two_full_n,
    input wire tx_fifo_full_n,
    input wire tx_fifo_half_full_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire [5:0] rx_flags_w = ~{rx_two_full_n, rx_two_half_full_n, rx_two_ready_n,
        rx_one_full_n, rx_one_half_full_n, rx_one_ready_n};
    wire [7:0] pins_w = {rx_flags_w, tx_fifo_full_n, tx_fifo_half_full_n};
    sequence status_take;
        rst_b && !status_read_strobe_n && !byte_sel
            && rx_one_output_enable_n && rx_two_output_enable_n;
    endsequence
    sequence bus_idle;
        status_read_strobe_n && rx_one_output_enable_n && rx_two_output_enable_n;
    endsequence
    reset_state_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        !rst_b |=> !host_bus_oe && host_bus_out == 16'h0000 && pins_w == 8'h03)
        else $error("outputs not at reset state");
    status_drive_a: assert property (status_take ##1 status_take |->
        host_bus_oe && host_bus_out[15:9] == 7'h00) else $error("status read not driven");
    tx_bits_a: assert property (status_take ##1 status_take |->
        host_bus_out[8:6] == {$past(tx_fifo_half_full), $past(tx_fifo_full),
        $past(tx_fifo_empty)}) else $error("transmit status bits wrong");
    rx_bits_a: assert property (status_take ##1 status_take |->
        host_bus_out[5:0] == rx_flags_w) else $error("receive status bits differ from pins");
    tx_full_pin_a: assert property ($past(rst_b) |->
        tx_fifo_full_n == !$past(tx_fifo_full)) else $error("transmit full pin wrong");
    tx_half_pin_a: assert property ($past(rst_b) |->
        tx_fifo_half_full_n != $past(tx_fifo_half_full)) else $error("transmit half pin wrong");
    full_chain_a: assert property (!rx_one_full_n || !rx_two_full_n |->
        (rx_one_full_n || !rx_one_half_full_n && !rx_one_ready_n)
        && (rx_two_full_n || !rx_two_half_full_n && !rx_two_ready_n))
        else $error("full flag without half and ready");
    bus_release_a: assert property (bus_idle |=> !host_bus_oe)
        else $error("bus driven while idle");
endmodule
bind swrx_status_map swrx_status_map_props i_swrx_status_map_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .status_read_strobe_n(status_read_strobe_n),
    .byte_sel(byte_sel), .rx_one_output_enable_n(rx_one_output_enable_n),
    .rx_two_output_enable_n(rx_two_output_enable_n), .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_full(tx_fifo_full), .tx_fifo_half_full(tx_fifo_half_full),
    .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
    .rx_one_ready_n(rx_one_ready_n), .rx_two_ready_n(rx_two_ready_n),
    .rx_one_half_full_n(rx_one_half_full_n), .rx_two_half_full_n(rx_two_half_full_n),
    .rx_one_full_n(rx_one_full_n), .rx_two_full_n(rx_two_full_n),
    .tx_fifo_full_n(tx_fifo_full_n), .tx_fifo_half_full_n(tx_fifo_half_full_n));

// ==== tb_swrx_status_map.sv ====
// testbench for swrx_status_map: status and word reads by a host
// assumes two swrx_line_src models feed the receivers at high speed
`timescale 1ns/100ps
module tb_swrx_status_map;
    localparam DEPTH = 4;
    localparam HALF = 2;
    reg clk_sys = 1'b0;
    reg rst_b = 1'b0;
    reg rate_check_disable_n = 1'b1;
    reg bus_bit_order_select = 1'b0;
    reg status_read_strobe_n = 1'b1;
    reg byte_sel = 1'b0;
    reg [1:0] en_n = 2'h3;
    reg [2:0] tx_flags = 3'h0;
    wire [1:0] code_one;
    wire [1:0] code_two;
    wire [15:0] host_bus_out;
    wire host_bus_oe;
    wire [7:0] pins_n;
    integer error_cnt = 0;
    integer num_checks = 0;
    integer i;
    reg [31:0] rd;
    always #5 clk_sys = ~clk_sys;
    swrx_line_src i_line_one (.clk_sys(clk_sys), .line_code(code_one));
    swrx_line_src i_line_two (.clk_sys(clk_sys), .line_code(code_two));
    swrx_status_map #(.RX_DEPTH(DEPTH), .RX_AW(2), .HALF_LEVEL(HALF)) i_swrx_status_map (
        .clk_sys(clk_sys), .rst_b(rst_b), .rx_one_line_code(code_one),
        .rx_two_line_code(code_two), .rx_one_slow_sel(1'b0), .rx_two_slow_sel(1'b0),
        .rate_check_disable_n(rate_check_disable_n), .bus_bit_order_select(bus_bit_order_select),
        .status_read_strobe_n(status_read_strobe_n), .byte_sel(byte_sel),
        .rx_one_output_enable_n(en_n[0]), .rx_two_output_enable_n(en_n[1]),
        .tx_fifo_empty(tx_flags[0]), .tx_fifo_full(tx_flags[1]),
        .tx_fifo_half_full(tx_flags[2]), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
        .rx_one_ready_n(pins_n[0]), .rx_one_half_full_n(pins_n[1]), .rx_one_full_n(pins_n[2]),
        .rx_two_ready_n(pins_n[3]), .rx_two_half_full_n(pins_n[4]), .rx_two_full_n(pins_n[5]),
        .tx_fifo_full_n(pins_n[6]), .tx_fifo_half_full_n(pins_n[7]));
    task finish_test;
        begin
            $display("checks %0d errors %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // top bit cleared and odd parity, so any parity flag reads back as zero
    function [31:0] mkw(input [31:0] s);
        begin
            mkw = {1'b0, s[30:0]};
            mkw[30] = mkw[30] ^ ~(^mkw);
        end
    endfunction
    function [31:0] map_exp(input [31:0] w, input ord);
        integer k;
        begin
            map_exp = {w[15:0], w[31:16]};
            if (!ord) begin
                map_exp = {w[12:8], w[30:29], w[31], 8'h00, w[28:13]};
                for (k = 0; k < 8; k = k + 1)
                    map_exp[23 - k] = w[k];
            end
        end
    endfunction
    task status_read(output [15:0] v);
        begin
            status_read_strobe_n <= 1'b0;
            byte_sel <= 1'b0;
            repeat (3) @(posedge clk_sys);
            v = host_bus_out;
            check("status_oe", {31'h0, host_bus_oe}, 32'h1);
            status_read_strobe_n <= 1'b1;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task read_word(input two, output [31:0] v);
        begin
            byte_sel <= 1'b0;
            en_n <= two ? 2'h1 : 2'h2;
            repeat (3) @(posedge clk_sys);
            v[31:16] = host_bus_out;
            en_n <= 2'h3;
            @(posedge clk_sys);
            byte_sel <= 1'b1;
            en_n <= two ? 2'h1 : 2'h2;
            repeat (3) @(posedge clk_sys);
            v[15:0] = host_bus_out;
            en_n <= 2'h3;
            repeat (3) @(posedge clk_sys);
        end
    endtask
    task check_flags(input integer n1, input integer n2);
        reg [15:0] v;
        reg [8:0] e;
        reg [7:0] p;
        begin
            e = {tx_flags, n2 >= DEPTH, n2 >= HALF, n2 > 0, n1 >= DEPTH, n1 >= HALF, n1 > 0};
            p = ~{e[8:7], e[5:0]};
            status_read(v);
            check("status", v, {7'h00, e});
            check("pins_n", pins_n, p);
        end
    endtask
    initial begin
        repeat (50000) @(posedge clk_sys);
        error_cnt = error_cnt + 1;
        $display("[ERR] watchdog expected done seen hang");
        finish_test;
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (400) @(posedge clk_sys);
        for (i = 0; i < 8; i = i + 1) begin
            tx_flags <= i[2:0];
            @(posedge clk_sys);
            check_flags(0, 0);
        end
        tx_flags <= 3'h1;
        // spacing at both ends of the accepted range
        fork
            i_line_one.send(mkw(32'h1357_9bdf), 8, 32);
            i_line_two.send(mkw(32'h2468_ace0), 12, 32);
        join
        check_flags(1, 1);
        read_word(1'b0, rd);
        check("word_one", rd, map_exp(mkw(32'h1357_9bdf), 1'b0));
        bus_bit_order_select <= 1'b1;
        read_word(1'b1, rd);
        check("word_two", rd, map_exp(mkw(32'h2468_ace0), 1'b1));
        check_flags(0, 0);
        fork
            i_line_one.send(mkw(32'h0f0f_1234), 10, 20);
            i_line_two.send(mkw(32'h0f0f_1234), 14, 32);
        join
        check_flags(0, 0);
        rate_check_disable_n <= 1'b0;
        i_line_two.send(mkw(32'h5a5a_3c3c), 14, 32);
        check_flags(0, 1);
        read_word(1'b1, rd);
        check("loose_word", rd, map_exp(mkw(32'h5a5a_3c3c), 1'b1));
        rate_check_disable_n <= 1'b1;
        // one word past full overwrites the last slot
        for (i = 1; i <= DEPTH + 1; i = i + 1) begin
            fork
                i_line_one.send(mkw(32'h1111_1111 * i), 10, 32);
                i_line_two.send(mkw(32'h2222_2222 * i), 10, 32);
            join
            check_flags(i > DEPTH ? DEPTH : i, i > DEPTH ? DEPTH : i);
        end
        for (i = 1; i <= DEPTH; i = i + 1) begin
            read_word(1'b0, rd);
            check("fill_one", rd, map_exp(mkw(32'h1111_1111 * (i + (i / DEPTH))), 1'b1));
            read_word(1'b1, rd);
            check("fill_two", rd, map_exp(mkw(32'h2222_2222 * (i + (i / DEPTH))), 1'b1));
        end
        check_flags(0, 0);
        finish_test;
    end
endmodule
